//--- hw/channel_buffer_io_control.sv
`timescale 1ns/1ns
`include "chan_io_defs.svh"
module channel_buffer_io_control
	import chan_io_pkg::*;
(
	input  wire logic        clock_i,     // 10 MHz clock
	input  wire logic        resetn_i,    // Async reset, active low
	input  wire logic [3:0]  reg_addr_i,  // Register index
	input  wire logic [17:0] reg_wdata_i, // Register write data
	input  wire logic        reg_wr_i,    // Write strobe
	input  wire logic        reg_rd_i,    // Read strobe
	output logic      [17:0] reg_rdata_o, // Read data, cycle after strobe
	input  wire logic        in_req_i,    // Input request
	input  wire logic [17:0] in_data_i,   // Data channel
	input  wire logic [17:0] in_pair_i,   // Partner: index, address or upper word
	output logic             in_ack_o,    // Input word taken
	input  wire logic        out_req_i,   // Output request
	input  wire logic [17:0] out_sel_i,   // Index or address with output request
	output logic      [17:0] out_data_o,  // Output word
	output logic      [17:0] out_pair_o,  // Output upper word
	output logic             out_ack_o,   // Output word valid
	input  wire logic        resume_i,    // Remote acknowledge
	input  wire logic        rtc_bit_i,   // Wired real-time counter bit
	output logic             mem_en_o,    // Main memory access
	output logic             mem_we_o,    // Main memory write
	output logic      [15:0] mem_addr_o,  // Main memory address
	output logic      [17:0] mem_wdata_o, // Main memory write word
	input  wire logic [17:0] mem_rdata_i, // Main memory read word, next cycle
	output logic             int_req_o,   // Interrupt request
	output logic      [7:0]  int_entry_o  // Entrance address of serviced interrupt
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic        slot;
	logic [1:0]  slot_idx;
	logic        eng_slot;
	logic        sw_slot;
	logic [17:0] cm_rd;
	logic [17:0] cm_sw_rd;
	logic        cm_we;
	logic [5:0]  cm_waddr;
	logic [17:0] cm_wdata;
	logic        eng_we;
	logic [5:0]  eng_waddr;
	logic [17:0] eng_wdata;
	logic [5:0]  eng_raddr;

	logic [17:0] ctrl_r,   ctrl_nxt;
	logic [2:0]  pend_r,   pend_nxt;
	logic [2:0]  honor_r,  honor_nxt;
	logic [5:0]  cmadr_r,  cmadr_nxt;
	logic        swp_r,    swp_nxt;
	logic [17:0] swd_r,    swd_nxt;
	logic [17:0] rdata_r,  rdata_nxt;
	logic        rtcp_r,   rtcp_nxt;
	logic        desig_r,  desig_nxt;

	eng_state_t  state_r,  state_nxt;
	logic        dir_r,    dir_nxt;
	logic [5:0]  base_r,   base_nxt;
	logic [17:0] cur_r,    cur_nxt;
	logic [17:0] end_r,    end_nxt;
	logic [17:0] lo_r,     lo_nxt;
	logic [17:0] hi_r,     hi_nxt;
	logic        abs_r,    abs_nxt;
	logic        wide_r,   wide_nxt;

	chan_mode_t  mode;
	logic        dual;
	logic        reinit;
	logic        in_go;
	logic        out_go;
	logic        done_evt;
	logic        clr_act;
	logic        rtc_edge;
	logic        intercomputer;
	logic        timeout_evt;
	logic [17:0] step;
	logic [17:0] next_cur;
	logic [2:0]  live;

	// ----------------------------------------
	// Control memory timing and storage
	// ----------------------------------------
	slot_timer u_slot (
		.clock_i    (clock_i),
		.resetn_i   (resetn_i),
		.slot_o     (slot),
		.slot_idx_o (slot_idx)
	);

	// Slot 0 belongs to the program side; slots 1-3 to the channel
	assign eng_slot = slot && (slot_idx != 2'h0);
	assign sw_slot  = slot && (slot_idx == 2'h0);
	assign cm_we    = eng_we | (swp_r & sw_slot);
	assign cm_waddr = eng_we ? eng_waddr : cmadr_r;
	assign cm_wdata = eng_we ? eng_wdata : swd_r;

	ctl_store u_cm (
		.clock_i (clock_i),
		.we_i    (cm_we),
		.waddr_i (cm_waddr),
		.wdata_i (cm_wdata),
		.raddr_i (eng_raddr),
		.rdata_o (cm_rd),
		.saddr_i (cmadr_r),
		.sdata_o (cm_sw_rd)
	);

	// ----------------------------------------
	// Transfer engine
	// ----------------------------------------
	assign mode     = chan_mode_t'(ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO]);
	assign dual     = ctrl_r[`CTRL_DUAL];
	assign reinit   = dir_r ? ctrl_r[`CTRL_OUT_REINIT] : ctrl_r[`CTRL_IN_REINIT];
	assign in_go    = in_req_i && ctrl_r[`CTRL_IN_ACT]
		&& (mode != EXTERNAL_ABSOLUTE_ADDRESS_MODE || dual);
	assign out_go   = out_req_i && ctrl_r[`CTRL_OUT_ACT]
		&& (mode != EXTERNAL_ABSOLUTE_ADDRESS_MODE || dual);
	assign step     = wide_r ? 18'h00002 : 18'h00001;
	assign next_cur = cur_r + step;

	always_comb
	begin
		state_nxt   = state_r;
		dir_nxt     = dir_r;
		base_nxt    = base_r;
		cur_nxt     = cur_r;
		end_nxt     = end_r;
		lo_nxt      = lo_r;
		hi_nxt      = hi_r;
		abs_nxt     = abs_r;
		wide_nxt    = wide_r;
		eng_we      = 1'b0;
		eng_waddr   = base_r;
		eng_wdata   = next_cur;
		eng_raddr   = base_r;
		mem_en_o    = 1'b0;
		mem_we_o    = 1'b0;
		mem_addr_o  = cur_r[15:0];
		mem_wdata_o = lo_r;
		in_ack_o    = 1'b0;
		out_ack_o   = 1'b0;
		done_evt    = 1'b0;
		clr_act     = 1'b0;
		unique case (state_r)
			S_IDLE:
			begin
				// Runs on peripheral request once the buffer is active (absolute mode also needs dual)
				if (in_go || out_go)
				begin
					dir_nxt  = !in_go;
					lo_nxt   = in_data_i;
					hi_nxt   = in_go ? in_pair_i : out_sel_i;
					abs_nxt  = (mode == EXTERNAL_ABSOLUTE_ADDRESS_MODE);
					wide_nxt = dual && (mode == NORMAL_MODE || mode == INTERCOMPUTER_MODE);
					// Index picks the control word pair
					if (mode == EXTERNAL_INDEX_MODE)
						base_nxt = in_go ? in_pair_i[5:0] : out_sel_i[5:0];
					else
						base_nxt = in_go ? `CM_IN_BCW : `CM_OUT_BCW;
					// Partner channel is the absolute address
					cur_nxt   = in_go ? in_pair_i : out_sel_i;
					state_nxt = (mode == EXTERNAL_ABSOLUTE_ADDRESS_MODE) ? S_MEM0 : S_RD_CUR;
				end
			end
			S_RD_CUR:
			begin
				if (eng_slot)
				begin
					cur_nxt   = cm_rd;
					state_nxt = S_RD_END;
				end
			end
			S_RD_END:
			begin
				eng_raddr = base_r + 6'h1;
				if (eng_slot)
				begin
					end_nxt   = cm_rd;
					state_nxt = S_MEM0;
				end
			end
			S_MEM0:
			begin
				mem_en_o  = 1'b1;
				mem_we_o  = !dir_r;
				state_nxt = S_MEM1;
			end
			S_MEM1:
			begin
				if (dir_r)
					lo_nxt = mem_rdata_i;
				mem_en_o    = wide_r;
				mem_we_o    = wide_r && !dir_r;
				mem_addr_o  = cur_r[15:0] + 16'h0001;
				mem_wdata_o = hi_r;
				state_nxt   = wide_r ? S_MEM2 : (abs_r ? S_ACK : S_WR_CUR);
			end
			S_MEM2:
			begin
				if (dir_r)
					hi_nxt = mem_rdata_i;
				state_nxt = abs_r ? S_ACK : S_WR_CUR;
			end
			S_WR_CUR:
			begin
				if (eng_slot)
				begin
					eng_we = 1'b1;
					if (next_cur == end_r)
					begin
						done_evt  = 1'b1;
						clr_act   = !reinit;
						state_nxt = reinit ? S_RE0 : S_ACK;
					end
					else
						state_nxt = S_ACK;
				end
			end
			S_RE0:
			begin
				eng_raddr = dir_r ? `CM_OUT_REINIT : `CM_IN_REINIT;
				eng_wdata = cm_rd;
				if (eng_slot)
				begin
					eng_we    = 1'b1;
					state_nxt = S_RE1;
				end
			end
			S_RE1:
			begin
				eng_raddr = (dir_r ? `CM_OUT_REINIT : `CM_IN_REINIT) + 6'h1;
				eng_waddr = base_r + 6'h1;
				eng_wdata = cm_rd;
				if (eng_slot)
				begin
					eng_we    = 1'b1;
					state_nxt = S_ACK;
				end
			end
			S_ACK:
			begin
				in_ack_o  = !dir_r;
				out_ack_o = dir_r;
				state_nxt = S_DROP;
			end
			S_DROP:
			begin
				if (!(dir_r ? out_req_i : in_req_i))
					state_nxt = S_IDLE;
			end
			default:
				state_nxt = S_IDLE;
		endcase
	end

	// ----------------------------------------
	// Time-out monitor and interrupts
	// ----------------------------------------
	assign intercomputer = (mode == INTERCOMPUTER_MODE);
	assign rtc_edge      = rtc_bit_i && !rtcp_r;
	assign timeout_evt   = rtc_edge && intercomputer && desig_r && !resume_i;
	assign live          = pend_r & honor_r;

	always_comb
	begin
		rtcp_nxt  = rtc_bit_i;
		desig_nxt = desig_r;
		if (resume_i)
			desig_nxt = 1'b0;
		if (rtc_edge)
			desig_nxt = 1'b1;
		if (!intercomputer)
			desig_nxt = 1'b0;

		pend_nxt = pend_r;
		if (reg_wr_i && reg_addr_i == `REG_INT_PEND)
			pend_nxt = pend_r & ~reg_wdata_i[2:0];
		pend_nxt[`INT_TIMEOUT] = pend_nxt[`INT_TIMEOUT] | timeout_evt;
		pend_nxt[`INT_IN_MON]  = pend_nxt[`INT_IN_MON] | (done_evt && !dir_r && ctrl_r[`CTRL_MON_EN]);
		pend_nxt[`INT_OUT_MON] = pend_nxt[`INT_OUT_MON] | (done_evt && dir_r && ctrl_r[`CTRL_MON_EN]);

		// Lowest bit wins; honour mask lets software skip the rest
		int_req_o = |live;
		if (live[`INT_TIMEOUT])
			int_entry_o = `ENTRY_TIMEOUT;
		else if (live[`INT_IN_MON])
			int_entry_o = `ENTRY_IN_MON;
		else if (live[`INT_OUT_MON])
			int_entry_o = `ENTRY_OUT_MON;
		else
			int_entry_o = 8'h00;
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		if (clr_act)
			ctrl_nxt[dir_r ? `CTRL_OUT_ACT : `CTRL_IN_ACT] = 1'b0;
		// Reinit request rides with the initiating write
		if (reg_wr_i && reg_addr_i == `REG_CTRL)
			ctrl_nxt = reg_wdata_i & `CTRL_MASK;
		honor_nxt = (reg_wr_i && reg_addr_i == `REG_INT_HONOR) ? reg_wdata_i[2:0] : honor_r;
		cmadr_nxt = (reg_wr_i && reg_addr_i == `REG_CM_ADDR) ? reg_wdata_i[5:0] : cmadr_r;
		swp_nxt   = swp_r && !sw_slot;
		swd_nxt   = swd_r;
		if (reg_wr_i && reg_addr_i == `REG_CM_DATA)
		begin
			swp_nxt = 1'b1;
			swd_nxt = reg_wdata_i;
		end
		rdata_nxt = 18'h00000;
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				`REG_CTRL:      rdata_nxt = ctrl_r;
				`REG_STATUS:    rdata_nxt = {11'h000, swp_r, desig_r, dir_r, state_r};
				`REG_INT_PEND:  rdata_nxt = {15'h0000, pend_r};
				`REG_INT_HONOR: rdata_nxt = {15'h0000, honor_r};
				`REG_CM_ADDR:   rdata_nxt = {12'h000, cmadr_r};
				`REG_CM_DATA:   rdata_nxt = cm_sw_rd;
				default:        rdata_nxt = 18'h00000;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ctrl_r  <= `CTRL_RESET;
			pend_r  <= 3'h0;
			honor_r <= `INT_HONOR_RESET;
			cmadr_r <= 6'h00;
			swp_r   <= 1'b0;
			swd_r   <= 18'h00000;
			rdata_r <= 18'h00000;
			rtcp_r  <= 1'b0;
			desig_r <= 1'b0;
			state_r <= S_IDLE;
			dir_r   <= 1'b0;
			base_r  <= 6'h00;
			cur_r   <= 18'h00000;
			end_r   <= 18'h00000;
			lo_r    <= 18'h00000;
			hi_r    <= 18'h00000;
			abs_r   <= 1'b0;
			wide_r  <= 1'b0;
		end
		else
		begin
			ctrl_r  <= ctrl_nxt;
			pend_r  <= pend_nxt;
			honor_r <= honor_nxt;
			cmadr_r <= cmadr_nxt;
			swp_r   <= swp_nxt;
			swd_r   <= swd_nxt;
			rdata_r <= rdata_nxt;
			rtcp_r  <= rtcp_nxt;
			desig_r <= desig_nxt;
			state_r <= state_nxt;
			dir_r   <= dir_nxt;
			base_r  <= base_nxt;
			cur_r   <= cur_nxt;
			end_r   <= end_nxt;
			lo_r    <= lo_nxt;
			hi_r    <= hi_nxt;
			abs_r   <= abs_nxt;
			wide_r  <= wide_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;
	assign out_data_o  = lo_r;
	assign out_pair_o  = hi_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	sequence seq_done_reinit;
		state_r == S_WR_CUR && done_evt && reinit;
	endsequence

	sequence seq_copy_pair;
		##[10:15] (state_r == S_RE1 && eng_we) ##1 (state_r == S_ACK);
	endsequence

	a_reinit_copy: assert property (seq_done_reinit |-> seq_copy_pair)
		else $error("reinit did not copy both control words");

	a_ack_single: assert property (in_ack_o |=> !in_ack_o && state_r == S_DROP)
		else $error("input acknowledge not a single pulse");

	a_monitor_each: assert property (done_evt && ctrl_r[`CTRL_MON_EN]
		|=> (dir_r ? pend_r[`INT_OUT_MON] : pend_r[`INT_IN_MON]))
		else $error("monitor interrupt missed at termination");

	a_timeout_mode_only: assert property ($rose(pend_r[`INT_TIMEOUT]) |-> $past(intercomputer))
		else $error("time-out raised outside intercomputer mode");

	a_desig_set: assert property (rtc_edge && intercomputer |=> desig_r)
		else $error("designator not set by counter bit");

	a_timeout_entry: assert property ($rose(pend_r[`INT_TIMEOUT]) && honor_r[`INT_TIMEOUT]
		|-> int_req_o && int_entry_o == `ENTRY_TIMEOUT)
		else $error("time-out entrance not selected");

	a_resume_clear: assert property (resume_i && !rtc_edge |=> !desig_r)
		else $error("resume did not clear designator");

	a_abs_dual: assert property (state_r == S_MEM0 && $past(state_r) == S_IDLE |-> $past(dual))
		else $error("absolute request answered without dual mode");

	a_wide_pair: assert property (state_r == S_MEM0 && wide_r
		|=> mem_en_o && mem_addr_o == $past(mem_addr_o) + 16'h0001)
		else $error("double word did not use next address");

	a_cm_own_slot: assert property (eng_we |-> slot && slot_idx != 2'h0)
		else $error("channel wrote control memory outside its slot");

endmodule

//--- hw/ctl_store.sv
`timescale 1ns/1ns
`include "chan_io_defs.svh"
module ctl_store
(
	input  wire logic        clock_i,  // System clock
	input  wire logic        we_i,     // Write enable
	input  wire logic [5:0]  waddr_i,  // Write index
	input  wire logic [17:0] wdata_i,  // Write word
	input  wire logic [5:0]  raddr_i,  // Channel read index
	output logic      [17:0] rdata_o,  // Channel read word
	input  wire logic [5:0]  saddr_i,  // Software read index
	output logic      [17:0] sdata_o   // Software read word
);
	logic [17:0] mem_r [`CM_DEPTH];

	always_ff @(posedge clock_i)
	begin
		if (we_i)
			mem_r[waddr_i] <= wdata_i;
	end

	assign rdata_o = mem_r[raddr_i];
	assign sdata_o = mem_r[saddr_i];

endmodule

//--- hw/slot_timer.sv
`timescale 1ns/1ns
`include "chan_io_defs.svh"
module slot_timer
(
	input  wire logic       clock_i,   // System clock
	input  wire logic       resetn_i,  // Async reset, active low
	output logic            slot_o,    // Pulse at end of each control memory cycle
	output logic [1:0]      slot_idx_o // Control memory cycle within main cycle
);
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic [1:0] idx_r;
	logic [1:0] idx_nxt;

	always_comb
	begin
		slot_o  = (cnt_r == 3'(`CM_CYCLE_CLKS - 1));
		cnt_nxt = slot_o ? 3'h0 : cnt_r + 3'h1;
		idx_nxt = slot_o ? idx_r + 2'h1 : idx_r;
	end

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cnt_r <= 3'h0;
			idx_r <= 2'h0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			idx_r <= idx_nxt;
		end
	end

	assign slot_idx_o = idx_r;

	a_slot_period: assert property (@(posedge clock_i) disable iff (!resetn_i)
		slot_o |=> !slot_o [*4] ##1 slot_o)
		else $error("control memory cycle is not five clocks");

endmodule

//--- include/chan_io_defs.svh
// Summary of operation
// - Activated buffers move words with no program help, paced by the peripheral.
// - Software may request automatic reinitiation when it initiates a channel buffer.
// - A completed buffer in auto reinit mode restarts by itself.
// - Reinit copies the two reinit control words into the active control words.
// - Monitor interrupt with auto reinit fires at every termination and restart.
// - Intercomputer time-out monitor works only in intercomputer mode.
// - Each arrival of the selected counter bit sets the time-out designator.
// - No acknowledge before the next arrival raises time-out, entrance at its register.
// - External index mode takes control words from the peripheral-named location.
// - Absolute addressing requests are answered only in active dual-channel mode.
// - In absolute mode one channel carries the address, the other the data.
// - Four 500 ns control memory cycles run per main memory cycle.
// - Channel logic reaches control memory in its own slots beside instruction flow.
// - Transfers are single 18-bit words or 36-bit words over a pair.
// - Highest-priority pending interrupt is serviced first; software honours or ignores others.
//
`ifndef CHAN_IO_DEFS_SVH
`define CHAN_IO_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS   100
`define CM_CYCLE_NS     500
`define CM_CYCLE_CLKS   ((`CM_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CM_PER_MM       4

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL        4'h0
`define REG_STATUS      4'h1
`define REG_INT_PEND    4'h2
`define REG_INT_HONOR   4'h3
`define REG_CM_ADDR     4'h4
`define REG_CM_DATA     4'h5

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_IN_ACT     0
`define CTRL_OUT_ACT    1
`define CTRL_IN_REINIT  2
`define CTRL_OUT_REINIT 3
`define CTRL_MON_EN     4
`define CTRL_DUAL       5
`define CTRL_MODE_LO    6
`define CTRL_MODE_HI    7
`define CTRL_MASK       18'h000ff
`define CTRL_RESET      18'h00000

// ----------------------------------------
// Interrupt bits and entrances
// ----------------------------------------
`define INT_TIMEOUT     0
`define INT_IN_MON      1
`define INT_OUT_MON     2
`define INT_HONOR_RESET 3'h7
`define ENTRY_TIMEOUT   8'h09
`define ENTRY_IN_MON    8'h70
`define ENTRY_OUT_MON   8'h60

// ----------------------------------------
// Control memory layout
// ----------------------------------------
`define CM_DEPTH        64
`define CM_OUT_BCW      6'h20
`define CM_IN_BCW       6'h30
`define CM_IN_REINIT    6'h10
`define CM_OUT_REINIT   6'h12

`endif

//--- include/chan_io_pkg.sv
package chan_io_pkg;

	typedef enum logic [1:0] {
		NORMAL_MODE                    = 2'b00,
		INTERCOMPUTER_MODE             = 2'b01,
		EXTERNAL_INDEX_MODE            = 2'b10,
		EXTERNAL_ABSOLUTE_ADDRESS_MODE = 2'b11
	} chan_mode_t;

	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_RD_CUR = 4'h1,
		S_RD_END = 4'h2,
		S_MEM0   = 4'h3,
		S_MEM1   = 4'h4,
		S_MEM2   = 4'h5,
		S_WR_CUR = 4'h6,
		S_RE0    = 4'h7,
		S_RE1    = 4'h8,
		S_ACK    = 4'h9,
		S_DROP   = 4'ha
	} eng_state_t;

endpackage

//--- sim/channel_buffer_io_control_bench.sv
`timescale 1ns/1ns
`include "chan_io_defs.svh"
module channel_buffer_io_control_bench;
	logic        clock_i, resetn_i, reg_wr_i, reg_rd_i, in_req_i, in_ack_o, out_req_i, out_ack_o;
	logic        resume_i, rtc_bit_i, mem_en_o, mem_we_o, int_req_o, go, dir, done, ok;
	logic [3:0]  reg_addr_i, stall;
	logic [7:0]  int_entry_o;
	logic [15:0] mem_addr_o;
	logic [17:0] reg_wdata_i, reg_rdata_o, in_data_i, in_pair_i, out_sel_i, out_data_o, out_pair_o;
	logic [17:0] mem_wdata_o, mem_rdata_i, got, got_pair, sel, dat, v;
	logic [17:0] mem [0:255];
	int          mismatches, samples_checked;

	channel_buffer_io_control dut_u (.clock_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .in_req_i, .in_data_i, .in_pair_i, .in_ack_o, .out_req_i, .out_sel_i, .out_data_o,
		.out_pair_o, .out_ack_o, .resume_i, .rtc_bit_i, .mem_en_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
		.mem_rdata_i, .int_req_o, .int_entry_o);

	periph_model pm_u (.clock_i, .resetn_i, .go_i(go), .dir_i(dir), .stall_i(stall), .sel_i(sel), .dat_i(dat),
		.in_ack_i(in_ack_o), .out_ack_i(out_ack_o), .out_data_i(out_data_o), .out_pair_i(out_pair_o),
		.in_req_o(in_req_i), .in_data_o(in_data_i), .in_pair_o(in_pair_i), .out_req_o(out_req_i),
		.out_sel_o(out_sel_i), .got_o(got), .got_pair_o(got_pair), .done_o(done));

	always #50 clock_i = ~clock_i;

	// ----------------------------------------
	// Main memory
	// ----------------------------------------
	always @(posedge clock_i)
	begin
		if (mem_en_o && mem_we_o)
			mem[mem_addr_o[7:0]] <= mem_wdata_o;
		mem_rdata_i <= mem_en_o ? mem[mem_addr_o[7:0]] : ~mem_rdata_i;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [17:0] d);
		@(posedge clock_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [17:0] d);
		@(posedge clock_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		@(negedge clock_i);
		d = reg_rdata_o;
	endtask

	task automatic cm_wr(input logic [5:0] a, input logic [17:0] d);
		wr(`REG_CM_ADDR, {12'h000, a});
		wr(`REG_CM_DATA, d);
		repeat (21) @(posedge clock_i);
		rd(`REG_STATUS, v);
		chk("cm_pending", {17'h00000, v[6]}, 18'h00000);
	endtask

	task automatic cm_rd(input logic [5:0] a, output logic [17:0] d);
		wr(`REG_CM_ADDR, {12'h000, a});
		rd(`REG_CM_DATA, d);
	endtask

	task automatic start(input logic d, input logic [3:0] s, input logic [17:0] x, input logic [17:0] y);
		@(posedge clock_i);
		go    <= 1'b1;
		dir   <= d;
		stall <= s;
		sel   <= x;
		dat   <= y;
		@(posedge clock_i);
		go <= 1'b0;
	endtask

	task automatic wait_done(input int lim, output logic ok_o);
		ok_o = 1'b0;
		for (int i = 0; i < lim && !ok_o; i++)
		begin
			@(posedge clock_i);
			if (done === 1'b1)
				ok_o = 1'b1;
		end
	endtask

	task automatic xfer(input logic d, input logic [3:0] s, input logic [17:0] x, input logic [17:0] y);
		start(d, s, x, y);
		wait_done(200, ok);
		chk("ack", {17'h00000, ok}, 18'h00001);
		repeat (30) @(posedge clock_i);
	endtask

	task automatic rtc_tick();
		@(posedge clock_i);
		rtc_bit_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		rtc_bit_i <= 1'b0;
		repeat (4) @(posedge clock_i);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		{clock_i, resetn_i, reg_wr_i, reg_rd_i, go, dir, resume_i, rtc_bit_i} = '0;
		{reg_addr_i, stall, reg_wdata_i, sel, dat, mem_rdata_i} = '0;
		for (int i = 0; i < 256; i++)
			mem[i] = 18'h01000 | 18'(i);
		repeat (12) @(posedge clock_i);
		resetn_i <= 1'b1;
		rd(`REG_CTRL, v);
		chk("ctrl_reset", v, 18'h00000);
		rd(`REG_INT_HONOR, v);
		chk("honor_reset", v, 18'h00007);
		wr(4'hf, 18'h3ffff);
		rd(4'hf, v);
		chk("unmapped", v, 18'h00000);
		wr(`REG_CTRL, 18'h000c1);
		start(1'b0, 4'h0, 18'h00040, 18'h2aaaa);
		wait_done(40, ok);
		chk("abs_refused", {17'h00000, ok}, 18'h00000);
		chk("abs_nowrite", mem[8'h40], 18'h01040);
		wr(`REG_CTRL, 18'h000e3);
		wait_done(60, ok);
		chk("abs_ack", {17'h00000, ok}, 18'h00001);
		repeat (5) @(posedge clock_i);
		chk("abs_in", mem[8'h40], 18'h2aaaa);
		xfer(1'b1, 4'h5, 18'h00040, 18'h00000);
		chk("abs_out", got, 18'h2aaaa);
		cm_wr(6'h20, 18'h00050);
		cm_wr(6'h21, 18'h00051);
		cm_wr(6'h12, 18'h00060);
		cm_wr(6'h13, 18'h00062);
		wr(`REG_CTRL, 18'h0001a);
		xfer(1'b1, 4'h9, 18'h00000, 18'h00000);
		chk("out_word", got, 18'h01050);
		cm_rd(6'h20, v);
		chk("reinit_cur", v, 18'h00060);
		cm_rd(6'h21, v);
		chk("reinit_end", v, 18'h00062);
		rd(`REG_CTRL, v);
		chk("still_active", v, 18'h0001a);
		rd(`REG_INT_PEND, v);
		chk("mon_pend", v, 18'h00004);
		chk("mon_entry", {10'h000, int_entry_o}, 18'h00060);
		wr(`REG_INT_PEND, 18'h00004);
		xfer(1'b1, 4'h0, 18'h00000, 18'h00000);
		chk("out_word2", got, 18'h01060);
		wr(`REG_CTRL, 18'h00012);
		xfer(1'b1, 4'h2, 18'h00000, 18'h00000);
		chk("out_word3", got, 18'h01061);
		rd(`REG_CTRL, v);
		chk("ended", v, 18'h00010);
		rd(`REG_INT_PEND, v);
		chk("mon_pend2", v, 18'h00004);
		cm_wr(6'h30, 18'h00080);
		cm_wr(6'h31, 18'h00084);
		wr(`REG_CTRL, 18'h00021);
		xfer(1'b0, 4'h3, 18'h3c3c3, 18'h05a5a);
		chk("wide_lo", mem[8'h80], 18'h05a5a);
		chk("wide_hi", mem[8'h81], 18'h3c3c3);
		cm_rd(6'h30, v);
		chk("wide_cur", v, 18'h00082);
		cm_wr(6'h20, 18'h00080);
		cm_wr(6'h21, 18'h00090);
		wr(`REG_CTRL, 18'h00022);
		xfer(1'b1, 4'h1, 18'h00000, 18'h00000);
		chk("wide_out", {got_pair[8:0], got[8:0]}, {9'h1c3, 9'h05a});
		cm_wr(6'h08, 18'h00090);
		cm_wr(6'h09, 18'h00095);
		wr(`REG_CTRL, 18'h000a1);
		xfer(1'b0, 4'h4, 18'h00008, 18'h11111);
		chk("index_in", mem[8'h90], 18'h11111);
		cm_rd(6'h08, v);
		chk("index_cur", v, 18'h00091);
		wr(`REG_CTRL, 18'h00000);
		rtc_tick();
		rtc_tick();
		rd(`REG_INT_PEND, v);
		chk("to_normal", {17'h00000, v[0]}, 18'h00000);
		wr(`REG_CTRL, 18'h00040);
		rtc_tick();
		rd(`REG_STATUS, v);
		chk("desig_set", {17'h00000, v[5]}, 18'h00001);
		@(posedge clock_i);
		resume_i <= 1'b1;
		@(posedge clock_i);
		resume_i <= 1'b0;
		rd(`REG_STATUS, v);
		chk("desig_clr", {17'h00000, v[5]}, 18'h00000);
		rtc_tick();
		rd(`REG_INT_PEND, v);
		chk("no_timeout", v, 18'h00004);
		rtc_tick();
		rd(`REG_INT_PEND, v);
		chk("timeout", v, 18'h00005);
		chk("to_entry", {10'h000, int_entry_o}, {10'h000, `ENTRY_TIMEOUT});
		wr(`REG_INT_HONOR, 18'h00006);
		repeat (2) @(posedge clock_i);
		chk("next_entry", {10'h000, int_entry_o}, 18'h00060);
		wr(`REG_INT_HONOR, 18'h00000);
		repeat (2) @(posedge clock_i);
		chk("ignored", {17'h00000, int_req_o}, 18'h00000);
		wr(`REG_INT_PEND, 18'h00007);
		rd(`REG_INT_PEND, v);
		chk("cleared", v, 18'h00000);
		results();
	end

	initial
	begin
		repeat (30000) @(posedge clock_i);
		mismatches++;
		results();
	end
endmodule

//--- sim/periph_model.sv
`timescale 1ns/1ns
module periph_model
(
	input  wire logic        clock_i,    // System clock
	input  wire logic        resetn_i,   // Async reset, active low
	input  wire logic        go_i,       // Start one transfer
	input  wire logic        dir_i,      // 1 output, 0 input
	input  wire logic [3:0]  stall_i,    // Idle cycles before request
	input  wire logic [17:0] sel_i,      // Index, address or upper word
	input  wire logic [17:0] dat_i,      // Input data word
	input  wire logic        in_ack_i,   // Input word taken
	input  wire logic        out_ack_i,  // Output word valid
	input  wire logic [17:0] out_data_i, // Output low word
	input  wire logic [17:0] out_pair_i, // Output upper word
	output logic             in_req_o,   // Input request
	output logic      [17:0] in_data_o,  // Data channel
	output logic      [17:0] in_pair_o,  // Partner channel
	output logic             out_req_o,  // Output request
	output logic      [17:0] out_sel_o,  // Output index or address
	output logic      [17:0] got_o,      // Captured low word
	output logic      [17:0] got_pair_o, // Captured upper word
	output logic             done_o      // Transfer finished
);
	logic       busy_r;
	logic [3:0] wait_r;

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			{busy_r, wait_r, in_req_o, out_req_o, done_o} <= '0;
			{in_data_o, in_pair_o, out_sel_o, got_o, got_pair_o} <= '0;
		end
		else
		begin
			done_o <= 1'b0;
			if (go_i)
			begin
				busy_r <= 1'b1;
				wait_r <= stall_i;
			end
			else if (busy_r && wait_r != 4'h0)
				wait_r <= wait_r - 4'h1;
			else if (busy_r && !in_req_o && !out_req_o && !dir_i)
			begin
				in_req_o  <= 1'b1;
				in_data_o <= dat_i;
				in_pair_o <= sel_i;
			end
			else if (busy_r && !in_req_o && !out_req_o)
			begin
				out_req_o <= 1'b1;
				out_sel_o <= sel_i;
			end
			if (in_req_o && in_ack_i)
			begin
				// Released lines show no stale word
				in_req_o  <= 1'b0;
				in_data_o <= ~in_data_o;
				in_pair_o <= ~in_pair_o;
				busy_r    <= 1'b0;
				done_o    <= 1'b1;
			end
			if (out_req_o && out_ack_i)
			begin
				out_req_o  <= 1'b0;
				out_sel_o  <= ~out_sel_o;
				got_o      <= out_data_i;
				got_pair_o <= out_pair_i;
				busy_r     <= 1'b0;
				done_o     <= 1'b1;
			end
		end
	end
endmodule
